// ==== design/pmg_pkg.sv ====
// Purpose: Shared constants for the peripheral pin mux and general port
// Assumes: AXI4-Lite with 32-bit data, one aligned word per register
// Notes: Offsets are byte addresses
package pmg_pkg;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] GLOBAL_MODE_OFF = 8'h00;
	localparam logic [ADDR_W-1:0] PORT_DIR_OFF = 8'h04;
	localparam logic [ADDR_W-1:0] PORT_VALUE_OFF = 8'h08;
	localparam logic [ADDR_W-1:0] PORT_STATUS_OFF = 8'h0c;
	localparam logic [ADDR_W-1:0] PORT_MASK_OFF = 8'h10;

	// ****************************************************************
	// Field positions of global_mode_reg
	// ****************************************************************
	localparam int CFG_LSB = 0;
	localparam int CFG_W = 3;
	localparam int NONPCI_BIT = 8;
	localparam int WRRD_BIT = 9;

	// ****************************************************************
	// Peripheral pin configurations
	// ****************************************************************
	localparam logic [CFG_W-1:0] CFG_LOCAL_ADDR = 3'h0;
	localparam logic [CFG_W-1:0] CFG_SPLIT = 3'h2;
	localparam logic [CFG_W-1:0] CFG_GENERAL = 3'h4;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [CFG_W-1:0] CFG_RESET = 3'h0;
	localparam logic [15:0] DIR_RESET = 16'h0000;
	localparam logic [15:0] VALUE_RESET = 16'h0000;
	localparam logic [15:0] STATUS_RESET = 16'h0000;
	localparam logic [15:0] MASK_RESET = 16'hffff;

	// Pin groups for the split configuration
	localparam logic [15:0] UPPER_HALF = 16'hff00;
	localparam logic [15:0] LOWER_HALF = 16'h00ff;

	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : pmg_pkg

// ==== design/pmg_pin_sampler.sv ====
// Purpose: Samples the shared pins and flags a level change per pin
// Assumes: Pin inputs synchronous to aclk
// Notes: First sample after reset only primes the history, no change
`timescale 1ns/1ps
`default_nettype none
module pmg_pin_sampler #(
	parameter int WIDTH = 16
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [WIDTH-1:0] pins_in,
	output logic [WIDTH-1:0] level,
	output logic [WIDTH-1:0] change
);

	logic primed_ff;
	logic nxt_primed;

	// Priming flag blocks a false change right after reset
	always_comb begin
		nxt_primed = 1'b1;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			primed_ff <= 1'b0;
		end else begin
			primed_ff <= nxt_primed;
		end
	end

	// ****************************************************************
	// Per pin sample and compare
	// ****************************************************************
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_pin
			logic level_ff;
			logic change_ff;
			logic nxt_level;
			logic nxt_change;

			// Compare fresh sample with previous one
			always_comb begin
				nxt_level = pins_in[i];
				nxt_change = primed_ff && (pins_in[i] != level_ff);
			end

			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					level_ff <= 1'b0;
					change_ff <= 1'b0;
				end else begin
					level_ff <= nxt_level;
					change_ff <= nxt_change;
				end
			end

			assign level[i] = level_ff;
			assign change[i] = change_ff;
		end
	endgenerate

endmodule : pmg_pin_sampler
`default_nettype wire

// ==== design/pmg_pin_mux_gpio.sv ====
// Purpose: Shared pin group mux, 16-bit general port, AXI4-Lite registers
// Assumes: Single clock aclk, synchronous active low reset
// Notes: Strap is captured once in the first cycle after reset release
`timescale 1ns/1ps
`default_nettype none
module pmg_pin_mux_gpio import pmg_pkg::*; #(
	parameter int PINS = 16
) (
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite slave
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Mode strap and host direction
	input wire logic nonpci_mode_strap,
	input wire logic host_drives_dir,
	input wire logic host_access_write,
	input wire logic wr_rd_in,
	output logic wr_rd_out,
	output logic wr_rd_oe,
	output logic nonpci_mode,
	output logic access_is_write,
	// Shared pin group
	input wire logic [PINS-1:0] local_address_lines,
	input wire logic [PINS-1:0] general_pins_in,
	output logic [PINS-1:0] general_pins_out,
	output logic [PINS-1:0] general_pins_oe,
	output logic [PINS-1:0] nonpci_mode_strap_address,
	output logic irq
);

	// ****************************************************************
	// Declarations
	// ****************************************************************
	logic aw_held_ff, w_held_ff, bvalid_ff, awready_ff, wready_ff;
	logic nxt_aw_held, nxt_w_held, nxt_bvalid, nxt_awready, nxt_wready;
	logic [ADDR_W-1:0] aw_addr_ff, nxt_aw_addr;
	logic [31:0] w_data_ff, nxt_w_data;
	logic [3:0] w_strb_ff, nxt_w_strb;
	logic [1:0] bresp_ff, nxt_bresp;
	logic arready_ff, rvalid_ff, nxt_arready, nxt_rvalid;
	logic [31:0] rdata_ff, nxt_rdata;
	logic [1:0] rresp_ff, nxt_rresp;
	logic do_write;
	logic [CFG_W-1:0] cfg_ff, nxt_cfg;
	logic [PINS-1:0] dir_ff, value_ff, status_ff, mask_ff;
	logic [PINS-1:0] nxt_dir, nxt_value, nxt_status, nxt_mask;
	logic irq_ff, nxt_irq;
	logic strap_taken_ff, nonpci_ff, nxt_strap_taken, nxt_nonpci;
	logic wr_out_ff, wr_oe_ff, acc_wr_ff;
	logic nxt_wr_out, nxt_wr_oe, nxt_acc_wr;
	logic [PINS-1:0] pin_out_ff, pin_oe_ff, nonpci_mode_strap_addr_ff;
	logic [PINS-1:0] nxt_pin_out, nxt_pin_oe, nxt_nonpci_mode_strap_addr;
	logic [PINS-1:0] port_en, addr_en;
	logic [PINS-1:0] pin_level, pin_change;
	logic [31:0] mode_word, value_word;

	// Byte lane merge for partial writes
	function automatic logic [31:0] merge_strb(input logic [31:0] old_w,
		input logic [31:0] new_w, input logic [3:0] strb);
		logic [31:0] res;
		res = old_w;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[8*b +: 8] = new_w[8*b +: 8];
			end
		end
		return res;
	endfunction : merge_strb

	// ****************************************************************
	// Pin sampling
	// ****************************************************************
	pmg_pin_sampler #(.WIDTH(PINS)) u_sampler (
		.aclk(aclk),
		.aresetn(aresetn),
		.pins_in(general_pins_in),
		.level(pin_level),
		.change(pin_change)
	);

	// ****************************************************************
	// Mode strap capture
	// ****************************************************************
	// Strap is a board level, taken once so the mode never moves
	always_comb begin
		nxt_strap_taken = 1'b1;
		nxt_nonpci = strap_taken_ff ? nonpci_ff : nonpci_mode_strap;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			strap_taken_ff <= 1'b0;
			nonpci_ff <= 1'b0;
		end else begin
			strap_taken_ff <= nxt_strap_taken;
			nonpci_ff <= nxt_nonpci;
		end
	end

	// ****************************************************************
	// Pin function select
	// ****************************************************************
	// Pins stay undriven until the strap is known, avoiding a clash
	always_comb begin
		port_en = '0;
		addr_en = '0;
		if (strap_taken_ff && !nonpci_ff) begin
			case (cfg_ff)
				CFG_LOCAL_ADDR: addr_en = '1;
				CFG_GENERAL: port_en = '1;
				CFG_SPLIT: begin
					port_en = UPPER_HALF;
					addr_en = LOWER_HALF;
				end
				default: begin
					port_en = '0;
					addr_en = '0;
				end
			endcase
		end
	end

	// Registered pin drive and non-PCI address capture
	always_comb begin
		nxt_pin_oe = (port_en & dir_ff) | addr_en;
		nxt_pin_out = (port_en & dir_ff & value_ff)
			| (addr_en & local_address_lines);
		nxt_nonpci_mode_strap_addr = nonpci_ff ? pin_level : '0;
		nxt_wr_oe = strap_taken_ff && nonpci_ff && host_drives_dir;
		nxt_wr_out = nxt_wr_oe && host_access_write;
		nxt_acc_wr = nonpci_ff && wr_rd_in;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_oe_ff <= '0;
			pin_out_ff <= '0;
			nonpci_mode_strap_addr_ff <= '0;
			wr_oe_ff <= 1'b0;
			wr_out_ff <= 1'b0;
			acc_wr_ff <= 1'b0;
		end else begin
			pin_oe_ff <= nxt_pin_oe;
			pin_out_ff <= nxt_pin_out;
			nonpci_mode_strap_addr_ff <= nxt_nonpci_mode_strap_addr;
			wr_oe_ff <= nxt_wr_oe;
			wr_out_ff <= nxt_wr_out;
			acc_wr_ff <= nxt_acc_wr;
		end
	end

	// ****************************************************************
	// AXI4-Lite write channel
	// ****************************************************************
	// Address and data accepted in either order, one write in flight
	always_comb begin
		nxt_aw_held = aw_held_ff;
		nxt_aw_addr = aw_addr_ff;
		nxt_w_held = w_held_ff;
		nxt_w_data = w_data_ff;
		nxt_w_strb = w_strb_ff;
		nxt_bvalid = bvalid_ff;
		nxt_bresp = bresp_ff;
		do_write = aw_held_ff && w_held_ff && !bvalid_ff;
		if (s_axi_awvalid && awready_ff) begin
			nxt_aw_held = 1'b1;
			nxt_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && wready_ff) begin
			nxt_w_held = 1'b1;
			nxt_w_data = s_axi_wdata;
			nxt_w_strb = s_axi_wstrb;
		end
		if (bvalid_ff && s_axi_bready) begin
			nxt_bvalid = 1'b0;
		end
		if (do_write) begin
			nxt_aw_held = 1'b0;
			nxt_w_held = 1'b0;
			nxt_bvalid = 1'b1;
			case ({aw_addr_ff[ADDR_W-1:2], 2'b00})
				GLOBAL_MODE_OFF, PORT_DIR_OFF, PORT_VALUE_OFF,
				PORT_STATUS_OFF, PORT_MASK_OFF: nxt_bresp = RESP_OKAY;
				default: nxt_bresp = RESP_SLVERR;
			endcase
		end
		nxt_awready = !nxt_aw_held && !nxt_bvalid;
		nxt_wready = !nxt_w_held && !nxt_bvalid;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_ff <= 1'b0;
			aw_addr_ff <= '0;
			w_held_ff <= 1'b0;
			w_data_ff <= '0;
			w_strb_ff <= '0;
			bvalid_ff <= 1'b0;
			bresp_ff <= RESP_OKAY;
			awready_ff <= 1'b0;
			wready_ff <= 1'b0;
		end else begin
			aw_held_ff <= nxt_aw_held;
			aw_addr_ff <= nxt_aw_addr;
			w_held_ff <= nxt_w_held;
			w_data_ff <= nxt_w_data;
			w_strb_ff <= nxt_w_strb;
			bvalid_ff <= nxt_bvalid;
			bresp_ff <= nxt_bresp;
			awready_ff <= nxt_awready;
			wready_ff <= nxt_wready;
		end
	end

	// ****************************************************************
	// Registers and change interrupts
	// ****************************************************************
	// A change arriving with a clear keeps its status bit set
	always_comb begin
		logic [31:0] merged;
		merged = '0;
		nxt_cfg = cfg_ff;
		nxt_dir = dir_ff;
		nxt_value = value_ff;
		nxt_mask = mask_ff;
		nxt_status = status_ff;
		if (do_write) begin
			case ({aw_addr_ff[ADDR_W-1:2], 2'b00})
				GLOBAL_MODE_OFF: begin
					merged = merge_strb({29'h0, cfg_ff}, w_data_ff, w_strb_ff);
					nxt_cfg = merged[CFG_LSB +: CFG_W];
				end
				PORT_DIR_OFF: begin
					merged = merge_strb({16'h0, dir_ff}, w_data_ff, w_strb_ff);
					nxt_dir = merged[PINS-1:0];
				end
				PORT_VALUE_OFF: begin
					merged = merge_strb({16'h0, value_ff}, w_data_ff, w_strb_ff);
					nxt_value = merged[PINS-1:0];
				end
				PORT_MASK_OFF: begin
					merged = merge_strb({16'h0, mask_ff}, w_data_ff, w_strb_ff);
					nxt_mask = merged[PINS-1:0];
				end
				PORT_STATUS_OFF: begin
					merged = merge_strb(32'h0, w_data_ff, w_strb_ff);
					nxt_status = status_ff & ~merged[PINS-1:0];
				end
				default: merged = '0;
			endcase
		end
		nxt_status = nxt_status | (pin_change & port_en);
		nxt_irq = |(status_ff & ~mask_ff);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg_ff <= CFG_RESET;
			dir_ff <= DIR_RESET;
			value_ff <= VALUE_RESET;
			status_ff <= STATUS_RESET;
			mask_ff <= MASK_RESET;
			irq_ff <= 1'b0;
		end else begin
			cfg_ff <= nxt_cfg;
			dir_ff <= nxt_dir;
			value_ff <= nxt_value;
			status_ff <= nxt_status;
			mask_ff <= nxt_mask;
			irq_ff <= nxt_irq;
		end
	end

	// ****************************************************************
	// AXI4-Lite read channel
	// ****************************************************************
	// Input pins read the sampled level, output pins read back the register
	always_comb begin
		mode_word = '0;
		mode_word[CFG_LSB +: CFG_W] = cfg_ff;
		mode_word[NONPCI_BIT] = nonpci_ff;
		mode_word[WRRD_BIT] = acc_wr_ff;
		value_word = {16'h0, (value_ff & dir_ff) | (pin_level & ~dir_ff)};
		nxt_arready = arready_ff || !rvalid_ff; // Also rises after reset
		nxt_rvalid = rvalid_ff;
		nxt_rdata = rdata_ff;
		nxt_rresp = rresp_ff;
		if (rvalid_ff && s_axi_rready) begin
			nxt_rvalid = 1'b0;
			nxt_arready = 1'b1;
		end
		if (s_axi_arvalid && arready_ff) begin
			nxt_arready = 1'b0;
			nxt_rvalid = 1'b1;
			nxt_rresp = RESP_OKAY;
			case ({s_axi_araddr[ADDR_W-1:2], 2'b00})
				GLOBAL_MODE_OFF: nxt_rdata = mode_word;
				PORT_DIR_OFF: nxt_rdata = {16'h0, dir_ff};
				PORT_VALUE_OFF: nxt_rdata = value_word;
				PORT_STATUS_OFF: nxt_rdata = {16'h0, status_ff};
				PORT_MASK_OFF: nxt_rdata = {16'h0, mask_ff};
				default: begin
					nxt_rdata = '0;
					nxt_rresp = RESP_SLVERR;
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_ff <= 1'b0;
			rvalid_ff <= 1'b0;
			rdata_ff <= '0;
			rresp_ff <= RESP_OKAY;
		end else begin
			arready_ff <= nxt_arready;
			rvalid_ff <= nxt_rvalid;
			rdata_ff <= nxt_rdata;
			rresp_ff <= nxt_rresp;
		end
	end

	// ****************************************************************
	// Outputs, all straight from flip-flops
	// ****************************************************************
	assign s_axi_awready = awready_ff;
	assign s_axi_wready = wready_ff;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_arready = arready_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;
	assign wr_rd_out = wr_out_ff;
	assign wr_rd_oe = wr_oe_ff;
	assign nonpci_mode = nonpci_ff;
	assign access_is_write = acc_wr_ff;
	assign general_pins_out = pin_out_ff;
	assign general_pins_oe = pin_oe_ff;
	assign nonpci_mode_strap_address = nonpci_mode_strap_addr_ff;
	assign irq = irq_ff;

endmodule : pmg_pin_mux_gpio
`default_nettype wire

// ==== dv/pmg_asserts.sv ====
// Purpose: Port-level checks for the pin mux and general port
// Assumes: One clock, synchronous active low reset
// Notes: Latencies follow the designer's hand-over figures
`timescale 1ns/1ps
`default_nettype none
module pmg_asserts #(
	parameter int PINS = 16
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic wr_rd_in,
	input wire logic wr_rd_oe,
	input wire logic nonpci_mode,
	input wire logic access_is_write,
	input wire logic [PINS-1:0] general_pins_in,
	input wire logic [PINS-1:0] general_pins_oe,
	input wire logic [PINS-1:0] nonpci_mode_strap_address,
	input wire logic irq
);
	// ********
	// Checks
	// ********
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic w_take;
	// Data beat taken, used to explain a falling request
	assign w_take = s_axi_wvalid && s_axi_wready;
	sequence s_pair_take;
		s_axi_awvalid && s_axi_awready && w_take;
	endsequence
	sequence s_resp_late;
		!s_axi_bvalid ##1 s_axi_bvalid;
	endsequence
	a_wrrd_pci_off: assert property (!nonpci_mode |-> !wr_rd_oe)
		else $error("write/read line driven in PCI mode");
	a_wrrd_owner: assert property (wr_rd_oe |-> nonpci_mode)
		else $error("write/read line driven outside non-PCI mode");
	a_wrrd_sampled: assert property (nonpci_mode && $past(nonpci_mode)
		|-> access_is_write == $past(wr_rd_in))
		else $error("write/read sample wrong");
	a_nonpci_pins_off: assert property (nonpci_mode
		|-> general_pins_oe == '0)
		else $error("shared pins driven in non-PCI mode");
	a_nonpci_mode_strap_addr: assert property (nonpci_mode && $past(nonpci_mode, 2)
		|-> nonpci_mode_strap_address == $past(general_pins_in, 2))
		else $error("non-PCI address not taken from pins");
	a_irq_clear: assert property ($fell(irq) |-> $past(w_take, 2)
		|| $past(w_take, 3) || $past(w_take, 4))
		else $error("request dropped without a register write");
	a_rd_answer: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid)
		else $error("read answer late");
	a_rd_single: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address accepted during answer");
	a_wr_answer: assert property (s_pair_take |-> ##1 s_resp_late)
		else $error("write response timing wrong");
endmodule : pmg_asserts
bind pmg_pin_mux_gpio pmg_asserts #(.PINS(PINS)) u_chk (
	.aclk(aclk), .aresetn(aresetn),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
	.wr_rd_in(wr_rd_in), .wr_rd_oe(wr_rd_oe), .nonpci_mode(nonpci_mode),
	.access_is_write(access_is_write),
	.general_pins_in(general_pins_in), .general_pins_oe(general_pins_oe),
	.nonpci_mode_strap_address(nonpci_mode_strap_address), .irq(irq)
);
`default_nettype wire

// ==== dv/pmg_board.sv ====
// Purpose: Board around the shared pins and the write/read line
// Assumes: Board drives every pin the device leaves free
// Notes: Write/read line has a pull-up when nobody drives it
`timescale 1ns/1ps
`default_nettype none
module pmg_board (
	input wire logic [15:0] board_level,
	input wire logic [15:0] general_pins_out,
	input wire logic [15:0] general_pins_oe,
	output logic [15:0] general_pins_in,
	input wire logic ext_drive,
	input wire logic ext_wr,
	input wire logic wr_rd_out,
	input wire logic wr_rd_oe,
	output logic wr_rd_in
);
	// Device wins where it drives, board level elsewhere
	assign general_pins_in = (general_pins_out & general_pins_oe)
		| (board_level & ~general_pins_oe);
	// Far host tells write from read when it owns the line
	assign wr_rd_in = wr_rd_oe ? wr_rd_out
		: (ext_drive ? ext_wr : 1'b1);
endmodule : pmg_board
`default_nettype wire

// ==== dv/tb.sv ====
// Purpose: Self-checking bench for the pin mux and general port
// Assumes: AXI4-Lite master tasks, board model on the pins
// Notes: A second reset with the strap high covers non-PCI mode
`timescale 1ns/1ps
`default_nettype none
module tb import pmg_pkg::*;;
	logic aclk = 1'b0;
	logic aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
	logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rv;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rr;
	logic nonpci_mode_strap, host_drives_dir, host_access_write;
	logic wr_rd_in, wr_rd_out, wr_rd_oe, nonpci_mode, access_is_write;
	logic ext_drive, ext_wr;
	logic [15:0] local_address_lines, general_pins_in, general_pins_out;
	logic [15:0] general_pins_oe, nonpci_mode_strap_address, board, eo, ev, dir, val;
	int err_total, n_checks;
	pmg_pin_mux_gpio dut (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.nonpci_mode_strap(nonpci_mode_strap),
		.host_drives_dir(host_drives_dir),
		.host_access_write(host_access_write),
		.wr_rd_in(wr_rd_in), .wr_rd_out(wr_rd_out), .wr_rd_oe(wr_rd_oe),
		.nonpci_mode(nonpci_mode), .access_is_write(access_is_write),
		.local_address_lines(local_address_lines),
		.general_pins_in(general_pins_in),
		.general_pins_out(general_pins_out),
		.general_pins_oe(general_pins_oe),
		.nonpci_mode_strap_address(nonpci_mode_strap_address), .irq(irq)
	);
	pmg_board u_board (
		.board_level(board), .general_pins_out(general_pins_out),
		.general_pins_oe(general_pins_oe),
		.general_pins_in(general_pins_in),
		.ext_drive(ext_drive), .ext_wr(ext_wr), .wr_rd_out(wr_rd_out),
		.wr_rd_oe(wr_rd_oe), .wr_rd_in(wr_rd_in)
	);
	// 200 MHz clock
	always #2.5 aclk = ~aclk;
	// ********
	// Tasks
	// ********
	task cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask : cyc
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// Address and data offered together, each dropped when taken
	task wr(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] st = 4'hf, input logic [1:0] er = RESP_OKAY);
		logic ad, dd;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= st;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		{ad, dd} = 2'h0;
		while (!(ad && dd)) begin
			@(posedge aclk);
			ad |= s_axi_awready;
			dd |= s_axi_wready;
			s_axi_awvalid <= !ad;
			s_axi_wvalid <= !dd;
		end
		do @(posedge aclk); while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		chk("bresp", er, s_axi_bresp);
	endtask : wr
	task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rd
	task rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
		rd(a, rv, rr);
		chk(nm, e, rv);
		chk("rresp", RESP_OKAY, rr);
	endtask : rdc
	task test_done;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : test_done
	// Watchdog, far beyond the few hundred cycles the run needs
	initial begin
		cyc(20000);
		err_total++;
		$display("[ERR] watchdog expected done seen hang");
		test_done();
	end
	// ********
	// Tests
	// ********
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
		{s_axi_arvalid, s_axi_rready, nonpci_mode_strap} = 3'h0;
		{host_drives_dir, host_access_write, ext_drive, ext_wr} = 4'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
		local_address_lines = 16'h5a3c;
		board = 16'hab00;
		{err_total, n_checks} = 0;
		cyc(12);
		aresetn <= 1'b1;
		cyc(3);
		rdc(GLOBAL_MODE_OFF, 32'h0, "mode");
		rdc(PORT_DIR_OFF, 32'h0, "dir");
		rdc(PORT_STATUS_OFF, 32'h0, "status");
		rdc(PORT_MASK_OFF, 32'hffff, "mask");
		{host_drives_dir, host_access_write} <= 2'h3;
		cyc(3);
		chk("wr_rd_oe", 0, wr_rd_oe);
		chk("is_write", 0, access_is_write);
		wr(GLOBAL_MODE_OFF, 32'h304);
		rdc(GLOBAL_MODE_OFF, 32'h4, "mode_ro");
		wr(8'h20, 32'h1, 4'hf, RESP_SLVERR);
		rd(8'h20, rv, rr);
		chk("unmapped", 0, rv);
		chk("unmapped_resp", RESP_SLVERR, rr);
		$display("test pci_basics done");
		// Every configuration code, pins compared with the settings
		dir = 16'h0f0f;
		val = 16'h1234;
		wr(PORT_DIR_OFF, dir);
		wr(PORT_VALUE_OFF, val);
		for (int c = 0; c < 8; c++) begin
			wr(GLOBAL_MODE_OFF, c);
			cyc(3);
			rdc(GLOBAL_MODE_OFF, c, "cfg");
			eo = (c == 0) ? 16'hffff : (c == 4) ? dir
				: (c == 2) ? {dir[15:8], 8'hff} : 16'h0;
			ev = (c == 0) ? local_address_lines : (c == 2)
				? {dir[15:8] & val[15:8], local_address_lines[7:0]} : dir & val;
			chk("pin_oe", eo, general_pins_oe);
			chk("pin_out", ev & eo, general_pins_out & eo);
		end
		rdc(PORT_VALUE_OFF, (val & dir) | (board & ~dir), "value");
		// Back to the general port, the loop left every pin undriven
		wr(GLOBAL_MODE_OFF, {29'h0, CFG_GENERAL});
		wr(PORT_DIR_OFF, 32'hffff0000, 4'h2);
		dir = 16'h000f;
		cyc(3);
		rdc(PORT_DIR_OFF, dir, "dir_lane");
		chk("pin_oe_lane", dir, general_pins_oe);
		$display("test pin_config done");
		// Change on a masked pin, then unmask it, change a masked pin and clear the first
		wr(PORT_STATUS_OFF, 32'hffff);
		rdc(PORT_STATUS_OFF, 32'h0, "status_clr");
		board <= board ^ 16'h0100;
		cyc(6);
		rdc(PORT_STATUS_OFF, 32'h100, "status_set");
		chk("irq_masked", 0, irq);
		wr(PORT_MASK_OFF, 32'hfeff);
		cyc(3);
		chk("irq_on", 1, irq);
		board <= board ^ 16'h0200;
		cyc(6);
		rdc(PORT_STATUS_OFF, 32'h300, "status_two");
		wr(PORT_STATUS_OFF, 32'h100);
		cyc(3);
		chk("irq_off", 0, irq);
		rdc(PORT_STATUS_OFF, 32'h200, "status_left");
		$display("test change_irq done");
		// Second reset with the strap high
		{host_drives_dir, host_access_write} <= 2'h0;
		aresetn <= 1'b0;
		nonpci_mode_strap <= 1'b1;
		cyc(12);
		aresetn <= 1'b1;
		cyc(4);
		chk("nonpci", 1, nonpci_mode);
		chk("np_pin_oe", 0, general_pins_oe);
		chk("nonpci_mode_strap_addr", board, nonpci_mode_strap_address);
		// Floating line reads high through its pull-up
		rdc(GLOBAL_MODE_OFF, 32'h300, "mode_np");
		{host_drives_dir, host_access_write} <= 2'h3;
		cyc(3);
		chk("np_oe", 1, wr_rd_oe);
		chk("np_out_w", 1, wr_rd_out);
		chk("np_is_w", 1, access_is_write);
		rdc(GLOBAL_MODE_OFF, 32'h300, "mode_w");
		host_access_write <= 1'b0;
		cyc(3);
		chk("np_out_r", 0, wr_rd_out);
		chk("np_is_r", 0, access_is_write);
		// Far host drives a read, so the pull-up level cannot pass
		{host_drives_dir, ext_drive, ext_wr} <= 3'h2;
		cyc(3);
		chk("np_oe_ext", 0, wr_rd_oe);
		chk("np_is_ext", 0, access_is_write);
		$display("test nonpci done");
		test_done();
	end
endmodule : tb
`default_nettype wire
